// ===== logic/spi_port_pkg.sv
`default_nettype none
package spi_port_pkg;
  // Control word bit positions
  localparam int CTL_DONE_BIT   = 7;
  localparam int CTL_MASTER_ENABLE_BIT_BIT  = 6;
  localparam int CTL_FAULT_BIT  = 5;
  localparam int CTL_WRITE_COLLISION_FLAG_BIT   = 4;
  localparam int CTL_SELHI_BIT  = 3;
  localparam int CTL_SELLO_BIT  = 2;
  localparam int CTL_PEN_BIT    = 0;
  // Reset values
  localparam logic [1:0] SEL_MODE_RST = 2'h1;
  localparam logic       MASTER_ENABLE_BIT_RST    = 1'h0;
  localparam logic       PEN_RST      = 1'h0;
  // Select-mode encodings
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_MULTI = 2'h1;
  // Timing: serial clock half period in system clocks
  localparam int SCK_HALF_CYC  = 4;
  localparam int BITS_PER_BYTE = 8;
  localparam int FIFO_DEPTH    = 16;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_LOW   = 2'b01,
    M_HIGH  = 2'b10
  } mst_state_e;

  typedef struct packed {
    logic [1:0] sel_mode;
    logic       master_en;
    logic       port_en;
  } ctl_s;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_s;
endpackage
`default_nettype wire

// ===== logic/byte_fifo.sv
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
    count_r <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ===== logic/spi_port.sv
// Notes on behaviour
// - Data out driven as master, input as slave
// - Master data out follows shift register MSB
// - Slave data out released when disabled/unselected
// - Three-wire slave drives MSB continuously
// - Clock only as master; unselected slave ignores
// - Mode 00: three-wire, slave always selected
// - Mode 01: select input; low select level stops master
// - Mode 1x: select output equals lower bit
// - Select pin unmapped in three-wire mode 00 only
// - Mode field bits 3:2, reset value 01
// - Master enable bit 6 makes master
// - Write buffered; loads shifter when empty
// - Transfer starts shifting and clocking at once
// - Completion sets flag bit 7, interrupt
// - Receive simultaneous; one flag for both
// - Receive MSB first, copy to buffer
// - Multi-master low select clears enables, faults
// - Fault interrupts; stays off until re-enabled
// - Write into full buffer sets collision, dropped
`default_nettype none
module spi_port #(
  parameter int TX_DEPTH = spi_port_pkg::FIFO_DEPTH
) (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic       CTL_WR,
  input  wire logic [7:0] CTL_WDATA,
  output logic      [7:0] CTL_STATUS,
  input  wire logic       DAT_WR,
  input  wire logic [7:0] DAT_WDATA,
  output logic            DAT_WREADY,
  input  wire logic       DAT_RD,
  output logic      [7:0] DAT_RDATA,
  output logic            RX_VALID,
  input  wire logic       FLAG_CLR,
  input  wire logic [7:0] FLAG_CLR_MASK,
  input  wire logic       INT_EN,
  output logic            IRQ,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MOSI_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       MISO_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       SCK_I,
  output logic            SEL_O,
  output logic            SEL_OE,
  input  wire logic       SEL_I,
  output logic            SEL_PIN_MAPPED
);
  localparam int HW = $clog2(spi_port_pkg::SCK_HALF_CYC + 1);

  spi_port_pkg::ctl_s       ctl_r;
  spi_port_pkg::mst_state_e mst_r;
  logic       done_r;
  logic       fault_r;
  logic       write_collision_flag_r;
  logic [7:0] shift_r;
  logic [7:0] rxbuf_r;
  logic       rx_valid_r;
  logic [3:0] bitcnt_r;
  logic [HW-1:0] half_r;
  logic       loaded_r;
  logic [2:0] sck_sync_r;
  logic [2:0] sel_sync_r;
  logic [2:0] mosi_sync_r;
  logic [2:0] miso_sync_r;
  logic       sck_lvl_r;
  logic       sel_lvl_r;
  logic       sck_out_r;
  logic       rx_bit_r;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;
  logic       fifo_ready;
  logic       is_master;
  logic       slave_sel;
  logic       sck_rise;
  logic       sck_fall;
  logic       sel_fall;
  logic       mst_done;
  logic       slv_done;
  logic       byte_done;
  logic       sel_level;
  logic       sel_stable;
  logic       sck_stable;

  function automatic logic agree(input logic [2:0] s);
    agree = (s[1] == s[2]);
  endfunction

  assign is_master  = ctl_r.port_en && ctl_r.master_en;
  assign sel_stable = agree(sel_sync_r);
  assign sck_stable = agree(sck_sync_r);
  assign sel_level  = sel_stable ? sel_sync_r[1] : sel_lvl_r;
  // Slave is selected permanently in three-wire mode
  assign slave_sel  = ctl_r.port_en && !ctl_r.master_en &&
                      ((ctl_r.sel_mode == spi_port_pkg::SEL_3WIRE) ||
                       !sel_level);
  assign sck_rise   = sck_stable && sck_sync_r[1] && !sck_lvl_r;
  assign sck_fall   = sck_stable && !sck_sync_r[1] && sck_lvl_r;
  assign sel_fall   = sel_stable && !sel_sync_r[1] && sel_lvl_r;

  // Three-flop sampling of pins; stage 0 feeds stage 1 only
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_sync_r  <= 3'h0;
      sel_sync_r  <= 3'h7;
      mosi_sync_r <= 3'h0;
      miso_sync_r <= 3'h0;
    end else begin
      sck_sync_r  <= {sck_sync_r[1:0], SCK_I};
      sel_sync_r  <= {sel_sync_r[1:0], SEL_I};
      mosi_sync_r <= {mosi_sync_r[1:0], MOSI_I};
      miso_sync_r <= {miso_sync_r[1:0], MISO_I};
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_lvl_r <= 1'h0;
      sel_lvl_r <= 1'h1;
    end else begin
      if (sck_stable) begin
        sck_lvl_r <= sck_sync_r[1];
      end
      if (sel_stable) begin
        sel_lvl_r <= sel_sync_r[1];
      end
    end
  end

  // Control: software write, fault clears enables
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_r.sel_mode  <= spi_port_pkg::SEL_MODE_RST;
      ctl_r.master_en <= spi_port_pkg::MASTER_ENABLE_BIT_RST;
      ctl_r.port_en   <= spi_port_pkg::PEN_RST;
    end else if (is_master && ctl_r.sel_mode == spi_port_pkg::SEL_MULTI &&
                 !sel_level) begin
      ctl_r.master_en <= 1'b0;
      ctl_r.port_en   <= 1'b0;
    end else if (CTL_WR) begin
      ctl_r.sel_mode  <= {CTL_WDATA[spi_port_pkg::CTL_SELHI_BIT],
                          CTL_WDATA[spi_port_pkg::CTL_SELLO_BIT]};
      ctl_r.master_en <= CTL_WDATA[spi_port_pkg::CTL_MASTER_ENABLE_BIT_BIT];
      ctl_r.port_en   <= CTL_WDATA[spi_port_pkg::CTL_PEN_BIT];
    end
  end

  assign fifo_pop = fifo_valid && !loaded_r && ctl_r.port_en;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .in_valid  (DAT_WR),
    .in_ready  (fifo_ready),
    .in_data   (DAT_WDATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  // Back-pressure on writers; writing into a full buffer is a collision
  assign DAT_WREADY = fifo_ready;

  // Master sequencer: half-period counter, 8 bits MSB first
  assign mst_done = (mst_r == spi_port_pkg::M_HIGH) &&
                    (half_r == HW'(spi_port_pkg::SCK_HALF_CYC - 1)) &&
                    (bitcnt_r == 4'(spi_port_pkg::BITS_PER_BYTE - 1));
  assign slv_done = slave_sel && sck_rise &&
                    (bitcnt_r == 4'(spi_port_pkg::BITS_PER_BYTE - 1));
  assign byte_done = mst_done || slv_done;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mst_r     <= spi_port_pkg::M_IDLE;
      half_r    <= '0;
      bitcnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      loaded_r  <= 1'b0;
      sck_out_r <= 1'b0;
      rx_bit_r  <= 1'b0;
    end else if (!ctl_r.port_en) begin
      mst_r     <= spi_port_pkg::M_IDLE;
      bitcnt_r  <= 4'h0;
      loaded_r  <= 1'b0;
      sck_out_r <= 1'b0;
    end else if (fifo_pop) begin
      shift_r  <= fifo_data;
      loaded_r <= 1'b1;
      bitcnt_r <= 4'h0;
      half_r   <= '0;
      if (is_master) begin
        mst_r <= spi_port_pkg::M_LOW;
      end
    end else if (is_master) begin
      case (mst_r)
        spi_port_pkg::M_LOW: begin
          if (half_r == HW'(spi_port_pkg::SCK_HALF_CYC - 1)) begin
            half_r    <= '0;
            sck_out_r <= 1'b1;
            mst_r     <= spi_port_pkg::M_HIGH;
            // Capture only; shifting here would move data out at the slave's sample edge
            rx_bit_r  <= miso_sync_r[2];
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        spi_port_pkg::M_HIGH: begin
          if (half_r == HW'(spi_port_pkg::SCK_HALF_CYC - 1)) begin
            half_r    <= '0;
            sck_out_r <= 1'b0;
            // Next data bit appears with the falling clock
            shift_r   <= {shift_r[6:0], rx_bit_r};
            if (mst_done) begin
              mst_r    <= spi_port_pkg::M_IDLE;
              loaded_r <= 1'b0;
              bitcnt_r <= 4'h0;
            end else begin
              mst_r    <= spi_port_pkg::M_LOW;
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        default: begin
          mst_r     <= spi_port_pkg::M_IDLE;
          sck_out_r <= 1'b0;
        end
      endcase
    end else begin
      // Slave: select falling edge in mode 01 restarts the bit count
      mst_r <= spi_port_pkg::M_IDLE;
      if (sel_fall && ctl_r.sel_mode == spi_port_pkg::SEL_MULTI) begin
        bitcnt_r <= 4'h0;
      end else if (slave_sel && sck_rise) begin
        shift_r <= {shift_r[6:0], mosi_sync_r[2]};
        if (slv_done) begin
          bitcnt_r <= 4'h0;
          loaded_r <= 1'b0;
        end else begin
          bitcnt_r <= bitcnt_r + 4'h1;
        end
      end
    end
  end

  // Receive buffer and flags; set wins over software clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rxbuf_r    <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (byte_done) begin
      rxbuf_r    <= mst_done ? {shift_r[6:0], rx_bit_r} : {shift_r[6:0], mosi_sync_r[2]};
      rx_valid_r <= 1'b1;
    end else if (DAT_RD) begin
      rx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r  <= 1'b0;
      fault_r <= 1'b0;
      write_collision_flag_r  <= 1'b0;
    end else begin
      if (byte_done) begin
        done_r <= 1'b1;
      end else if (FLAG_CLR && FLAG_CLR_MASK[spi_port_pkg::CTL_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      if (is_master && ctl_r.sel_mode == spi_port_pkg::SEL_MULTI && !sel_level) begin
        fault_r <= 1'b1;
      end else if (FLAG_CLR && FLAG_CLR_MASK[spi_port_pkg::CTL_FAULT_BIT]) begin
        fault_r <= 1'b0;
      end
      if (DAT_WR && !fifo_ready) begin
        write_collision_flag_r <= 1'b1;
      end else if (FLAG_CLR && FLAG_CLR_MASK[spi_port_pkg::CTL_WRITE_COLLISION_FLAG_BIT]) begin
        write_collision_flag_r <= 1'b0;
      end
    end
  end

  assign CTL_STATUS = {done_r, ctl_r.master_en, fault_r, write_collision_flag_r,
                       ctl_r.sel_mode, 1'b0, ctl_r.port_en};
  assign DAT_RDATA  = rxbuf_r;
  assign RX_VALID   = rx_valid_r;
  assign IRQ        = INT_EN && (done_r || fault_r || write_collision_flag_r);

  // Pins
  assign MOSI_O  = shift_r[7];
  assign MOSI_OE = is_master;
  assign MISO_O  = shift_r[7];
  assign MISO_OE = slave_sel;
  assign SCK_O   = sck_out_r;
  assign SCK_OE  = is_master;
  assign SEL_O   = ctl_r.sel_mode[0];
  assign SEL_OE  = ctl_r.port_en && ctl_r.sel_mode[1];
  assign SEL_PIN_MAPPED = (ctl_r.sel_mode != spi_port_pkg::SEL_3WIRE);

  a_miso_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    !ctl_r.port_en |-> !MISO_OE) else $error("data out driven while disabled");
  a_fault_disable: assert property (@(posedge MCLK) disable iff (!RST_N)
    (is_master && ctl_r.sel_mode == spi_port_pkg::SEL_MULTI && !sel_level)
    |=> (!ctl_r.master_en && !ctl_r.port_en && fault_r)) else $error("fault not taken");
  a_sel_out_level: assert property (@(posedge MCLK) disable iff (!RST_N)
    (SEL_OE && $past(CTL_WR)) |-> SEL_O == $past(CTL_WDATA[spi_port_pkg::CTL_SELLO_BIT]))
    else $error("select level");
  a_sel_out_steady: assert property (@(posedge MCLK) disable iff (!RST_N)
    (SEL_OE && $past(SEL_OE) && !$past(CTL_WR)) |-> $stable(SEL_O))
    else $error("select output moved without a write");
  a_slave_ignores_sck: assert property (@(posedge MCLK) disable iff (!RST_N)
    (ctl_r.port_en && !ctl_r.master_en && !slave_sel && !fifo_pop)
    |=> $stable(bitcnt_r)) else $error("unselected slave counted a clock edge");
  a_fault_sticky: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fault_r && !(FLAG_CLR && FLAG_CLR_MASK[spi_port_pkg::CTL_FAULT_BIT]))
    |=> fault_r) else $error("fault flag lost");
  a_port_stays_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!ctl_r.port_en && !CTL_WR) |=> !ctl_r.port_en) else $error("port enabled itself");
  a_done_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    mst_done |=> done_r) else $error("completion flag missing");
  a_master_starts: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fifo_pop && is_master) |=> mst_r == spi_port_pkg::M_LOW) else $error("no start");
  a_sck_only_master: assert property (@(posedge MCLK) disable iff (!RST_N)
    SCK_OE |-> ctl_r.master_en) else $error("clock driven as slave");
  a_write_collision_flag_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    (DAT_WR && !fifo_ready) |=> write_collision_flag_r) else $error("collision flag missing");
  a_mosi_msb: assert property (@(posedge MCLK) disable iff (!RST_N)
    MOSI_OE |-> MOSI_O == shift_r[7]) else $error("data out not msb");
  c_master_byte: cover property (@(posedge MCLK) mst_done);
  c_slave_byte: cover property (@(posedge MCLK) slv_done);
  c_fault: cover property (@(posedge MCLK) $rose(fault_r));
  c_slave_clock: cover property (@(posedge MCLK) slave_sel && sck_fall);
  c_collision: cover property (@(posedge MCLK) $rose(write_collision_flag_r));
endmodule
`default_nettype wire

// ===== dv/spi_slave_model.sv
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  output logic            miso,
  output logic      [7:0] rx_last,
  output int              rx_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt;
  logic       smp;
  initial begin
    shift_r = 8'h00;
    bit_cnt = 3'h0;
    smp = 1'b0;
    rx_last = 8'h00;
    rx_count = 0;
    miso = 1'b0;
  end
  always @(posedge sck) begin
    if (!sel_n) smp = mosi;
  end
  // Shifting in and out together makes each reply the byte held before
  always @(negedge sck or posedge load) begin
    if (load) begin
      shift_r = load_data;
      bit_cnt = 3'h0;
    end else if (!sel_n) begin
      shift_r = {shift_r[6:0], smp};
      bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h0) begin
        rx_last = shift_r;
        rx_count = rx_count + 1;
      end
    end
  end
  // No pull on this line: a released bit flips so stale data never passes
  always @(sel_n or shift_r) begin
    if (!sel_n) miso = shift_r[7];
    else miso = ~miso;
  end
endmodule
`default_nettype wire

// ===== dv/spi_master_and_select_modes_bench.sv
`default_nettype none
module spi_master_and_select_modes_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       MCLK = 1'b0;
  logic       RST_N = 1'b0;
  logic       CTL_WR = 1'b0;
  logic [7:0] CTL_WDATA = 8'h00;
  logic       DAT_WR = 1'b0;
  logic [7:0] DAT_WDATA = 8'h00;
  logic       DAT_RD = 1'b0;
  logic       FLAG_CLR = 1'b0;
  logic [7:0] FLAG_CLR_MASK = 8'h00;
  logic       INT_EN = 1'b1;
  logic [7:0] CTL_STATUS, DAT_RDATA, m_last;
  logic       DAT_WREADY, RX_VALID, IRQ, SEL_PIN_MAPPED;
  logic       MOSI_O, MOSI_OE, MISO_O, MISO_OE, SCK_O, SCK_OE, SEL_O, SEL_OE;
  logic       b_mosi = 1'b0;
  logic       b_sck = 1'b0;
  logic       b_sel = 1'b1;
  logic       m_load = 1'b0;
  logic       mosi_w, miso_w, sck_w, sel_w, m_miso;
  int         m_count;
  int         err_total = 0;
  int         n_checks = 0;

  assign mosi_w = MOSI_OE ? MOSI_O : b_mosi;
  assign sck_w  = SCK_OE ? SCK_O : b_sck;
  assign sel_w  = SEL_OE ? SEL_O : b_sel;
  assign miso_w = MISO_OE ? MISO_O : m_miso;
  always #2.5 MCLK = ~MCLK;

  spi_port spi_port_inst (
    .MCLK(MCLK), .RST_N(RST_N), .CTL_WR(CTL_WR), .CTL_WDATA(CTL_WDATA),
    .CTL_STATUS(CTL_STATUS), .DAT_WR(DAT_WR), .DAT_WDATA(DAT_WDATA),
    .DAT_WREADY(DAT_WREADY), .DAT_RD(DAT_RD), .DAT_RDATA(DAT_RDATA), .RX_VALID(RX_VALID),
    .FLAG_CLR(FLAG_CLR), .FLAG_CLR_MASK(FLAG_CLR_MASK), .INT_EN(INT_EN), .IRQ(IRQ),
    .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MOSI_I(mosi_w), .MISO_O(MISO_O),
    .MISO_OE(MISO_OE), .MISO_I(miso_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SCK_I(sck_w),
    .SEL_O(SEL_O), .SEL_OE(SEL_OE), .SEL_I(sel_w), .SEL_PIN_MAPPED(SEL_PIN_MAPPED)
  );
  // Single slave on the bus, selected by the device's own select or the bench
  spi_slave_model spi_slave_model_inst (
    .sck(sck_w), .mosi(mosi_w), .sel_n(sel_w), .load(m_load), .load_data(8'h5A),
    .miso(m_miso), .rx_last(m_last), .rx_count(m_count)
  );

  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic ctl_wr(input logic [7:0] d);
    @(negedge MCLK);
    CTL_WR = 1'b1;
    CTL_WDATA = d;
    @(negedge MCLK);
    CTL_WR = 1'b0;
    cyc(3);
  endtask
  task automatic dat_wr(input logic [7:0] d);
    @(negedge MCLK);
    DAT_WR = 1'b1;
    DAT_WDATA = d;
    @(negedge MCLK);
    DAT_WR = 1'b0;
  endtask
  task automatic dat_rd();
    @(negedge MCLK);
    DAT_RD = 1'b1;
    @(negedge MCLK);
    DAT_RD = 1'b0;
  endtask
  task automatic flag_clr(input logic [7:0] m);
    @(negedge MCLK);
    FLAG_CLR = 1'b1;
    FLAG_CLR_MASK = m;
    @(negedge MCLK);
    FLAG_CLR = 1'b0;
    cyc(1);
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 3000 && RX_VALID !== 1'b1; i++) @(negedge MCLK);
    chk_bit("rx valid", 1'b1, RX_VALID);
  endtask
  // Link clock moves on falling system edges; stands low between bytes
  task automatic slv_byte(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge MCLK);
    for (int i = 7; i >= 0; i--) begin
      b_mosi = tx[i];
      #80;
      b_sck = 1'b1;
      rx[i] = MISO_O;
      #80;
      b_sck = 1'b0;
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    close_out();
  end

  initial begin
    logic [7:0] got;
    int         n;
    int         base;
    cyc(2);
    RST_N = 1'b1;
    m_load = 1'b1;
    cyc(1);
    m_load = 1'b0;
    chk_byte("status reset", 8'h04, CTL_STATUS);
    chk_bit("sel mapped reset", 1'b1, SEL_PIN_MAPPED);
    chk_bit("mosi oe reset", 1'b0, MOSI_OE);
    chk_bit("miso oe reset", 1'b0, MISO_OE);
    ctl_wr(8'h41);
    b_sel = 1'b0;
    chk_byte("status master", 8'h41, CTL_STATUS);
    chk_bit("sel mapped 3w", 1'b0, SEL_PIN_MAPPED);
    chk_bit("mosi oe master", 1'b1, MOSI_OE);
    chk_bit("sck oe master", 1'b1, SCK_OE);
    dat_wr(8'hA5);
    dat_wr(8'h3C);
    wait_rx();
    chk_byte("rx byte 1", 8'h5A, DAT_RDATA);
    chk_byte("sent byte 1", 8'hA5, m_last);
    chk_bit("done flag", 1'b1, CTL_STATUS[7]);
    chk_bit("irq done", 1'b1, IRQ);
    INT_EN = 1'b0;
    cyc(1);
    chk_bit("irq masked", 1'b0, IRQ);
    INT_EN = 1'b1;
    dat_rd();
    flag_clr(8'hFF);
    chk_bit("done cleared", 1'b0, CTL_STATUS[7]);
    wait_rx();
    chk_byte("rx byte 2", 8'hA5, DAT_RDATA);
    chk_byte("sent byte 2", 8'h3C, m_last);
    dat_rd();
    flag_clr(8'hFF);
    base = m_count;
    n = 0;
    while (DAT_WREADY === 1'b1 && n < 20) begin
      DAT_WR = 1'b1;
      DAT_WDATA = 8'h10 + 8'(n);
      n++;
      @(negedge MCLK);
    end
    DAT_WR = 1'b1;
    DAT_WDATA = 8'hEE;
    @(negedge MCLK);
    DAT_WR = 1'b0;
    cyc(2);
    chk_bit("collision flag", 1'b1, CTL_STATUS[4]);
    chk_bit("fifo refuses", 1'b0, DAT_WREADY);
    for (int i = 0; i < 20000 && m_count < base + n; i++) @(negedge MCLK);
    cyc(100);
    chk_byte("bytes drained", 8'(n), 8'(m_count - base));
    chk_byte("last byte sent", 8'h10 + 8'(n - 1), m_last);
    flag_clr(8'hFF);
    dat_rd();
    ctl_wr(8'h4D);
    chk_bit("sel oe 4w", 1'b1, SEL_OE);
    chk_bit("sel level hi", 1'b1, SEL_O);
    chk_bit("sel mapped 4w", 1'b1, SEL_PIN_MAPPED);
    ctl_wr(8'h49);
    chk_bit("sel level lo", 1'b0, SEL_O);
    dat_wr(8'h81);
    cyc(20);
    chk_bit("sel steady", 1'b0, SEL_O);
    wait_rx();
    chk_byte("sent 4w", 8'h81, m_last);
    chk_byte("rx 4w", 8'h10 + 8'(n - 1), DAT_RDATA);
    chk_bit("sel after", 1'b0, SEL_O);
    dat_rd();
    b_sel = 1'b1;
    flag_clr(8'hFF);
    // Park disabled in mode 01 first so the select samplers see the bench's high level
    ctl_wr(8'h04);
    ctl_wr(8'h45);
    chk_bit("master before fault", 1'b1, CTL_STATUS[6]);
    b_sel = 1'b0;
    cyc(8);
    chk_byte("status fault", 8'h24, CTL_STATUS);
    chk_bit("mosi oe fault", 1'b0, MOSI_OE);
    chk_bit("irq fault", 1'b1, IRQ);
    b_sel = 1'b1;
    cyc(8);
    chk_byte("stays off", 8'h24, CTL_STATUS);
    flag_clr(8'h20);
    ctl_wr(8'h45);
    chk_byte("re-enabled", 8'h45, CTL_STATUS);
    ctl_wr(8'h05);
    chk_bit("mosi oe slave", 1'b0, MOSI_OE);
    chk_bit("sck oe slave", 1'b0, SCK_OE);
    chk_bit("miso oe unsel", 1'b0, MISO_OE);
    dat_wr(8'hC3);
    slv_byte(8'h96, got);
    cyc(10);
    chk_bit("clock ignored", 1'b0, RX_VALID);
    b_sel = 1'b0;
    cyc(20);
    chk_bit("miso oe sel", 1'b1, MISO_OE);
    slv_byte(8'h96, got);
    chk_byte("slave reply", 8'hC3, got);
    wait_rx();
    chk_byte("slave rx", 8'h96, DAT_RDATA);
    b_sel = 1'b1;
    dat_rd();
    ctl_wr(8'h01);
    chk_bit("miso oe 3w slave", 1'b1, MISO_OE);
    chk_bit("sel mapped 3w slv", 1'b0, SEL_PIN_MAPPED);
    ctl_wr(8'h00);
    chk_bit("miso oe disabled", 1'b0, MISO_OE);
    close_out();
  end
endmodule
`default_nettype wire
